// File: hw/pulse_sequence_timer.sv
`timescale 1ns/1ps
// Summary of operation
// - One 16-bit up-counter on the 4 MHz tick is the shared time base.
// - Counter equal to period value returns to zero, starting a new period.
// - Oscillator clock is halved to make the 4 MHz timer tick.
// - The 4 MHz clock is driven out on a pin for the host.
// - Software sets rising and falling edge of eleven control signals.
// - Each output has its own compare of counter against start and stop.
// - Output drops in the cycle after the counter equals its stop value.
// - Equal start and stop values give a pulse of one timer cycle.
// - Edges count in 4 MHz cycles, a 0.25 us step.
// - ADC clear output has four start/stop pairs, four pulses per period.
// - Edge values are taken unchecked; software avoids overlap and overrun.
// - Edges live in 16-bit registers 01h to 1Ch, period at 1Dh.
// - Host writes all start, stop and period values over the serial port.
// - Sample outputs steer capacitor charging, convert outputs feed the ADC.
module pulse_sequence_timer
   import pulse_timer_pkg::*;
(
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   input  wire logic ce_i,
   input  wire logic osc_clk_i,
   input  wire logic spi_cs_n_i,
   input  wire logic spi_sclk_i,
   input  wire logic spi_mosi_i,
   output logic      spi_miso_o,
   output logic      clk_out_o,
   output logic      red_sample_o,
   output logic      red_light_o,
   output logic      red_ambient_sample_o,
   output logic      ir_sample_o,
   output logic      ir_light_o,
   output logic      ir_ambient_sample_o,
   output logic      red_convert_o,
   output logic      red_ambient_convert_o,
   output logic      ir_convert_o,
   output logic      ir_ambient_convert_o,
   output logic      adc_clear_o
);

   // ==========================================================
   // Reset release
   logic rst_meta;
   logic rst_sync;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // ==========================================================
   // Clock divider and tick
   logic osc_q;
   logic osc_prev;
   logic osc_rise;
   logic tick;

   assign osc_rise = osc_q & ~osc_prev;
   assign tick     = osc_rise & clk_out_o;

   always_ff @(posedge mclk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         osc_q     <= 1'b0;
         osc_prev  <= 1'b0;
         clk_out_o <= 1'b0;
      end else if (ce_i) begin
         osc_q    <= osc_clk_i;
         osc_prev <= osc_q;
         if (osc_rise) begin
            clk_out_o <= ~clk_out_o;
         end
      end
   end

   // ==========================================================
   // Serial port
   spi_state_t        state;
   spi_state_t        next_state;
   logic [4:0]        bit_cnt;
   logic [7:0]        addr;
   logic [22:0]       data_sh;
   logic [23:0]       rd_sh;
   logic              read_en;
   logic              sclk_q;
   logic              sclk_prev;
   logic              sclk_rise;
   logic              sclk_fall;
   logic              addr_done;
   logic              wr_fire;
   logic              wr_allowed;
   logic [7:0]        rd_addr;
   logic [23:0]       wr_data;
   logic              rd_in_map;
   logic [15:0]       rd_value;
   logic [15:0]       regs [1:REG_LAST];
   logic [CNT_W-1:0]  cnt;

   assign sclk_rise  = sclk_q & ~sclk_prev;
   assign sclk_fall  = ~sclk_q & sclk_prev;
   assign addr_done  = (state == SPI_ADDR) & sclk_rise & (bit_cnt == ADDR_LAST_BIT);
   assign wr_fire    = (state == SPI_DATA) & sclk_rise & (bit_cnt == DATA_LAST_BIT) & ~spi_cs_n_i;
   assign wr_data    = {data_sh, spi_mosi_i};
   assign wr_allowed = (addr == REG_CONTROL) | ~read_en;
   assign rd_addr    = {addr[6:0], spi_mosi_i};
   assign rd_in_map  = (rd_addr >= REG_RED_SAMPLE_START) & (rd_addr <= REG_PERIOD_TERMINAL_COUNT);
   assign rd_value   = (rd_addr == REG_CONTROL)     ? {15'h0000, read_en} :
                       rd_in_map                    ? regs[rd_addr[4:0]] :
                       (rd_addr == REG_TIMER_VALUE) ? cnt : 16'h0000;

   always_comb begin
      next_state = state;
      if (spi_cs_n_i) begin
         next_state = SPI_IDLE;
      end else begin
         case (state)
            SPI_IDLE: begin
               next_state = SPI_ADDR;
            end
            SPI_ADDR: begin
               if (addr_done) begin
                  next_state = SPI_DATA;
               end
            end
            SPI_DATA: begin
               if (wr_fire) begin
                  next_state = SPI_DONE;
               end
            end
            SPI_DONE: begin
               next_state = SPI_DONE;
            end
            default: begin
               next_state = SPI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         state     <= SPI_IDLE;
         sclk_q    <= 1'b0;
         sclk_prev <= 1'b0;
         bit_cnt   <= 5'h00;
      end else if (ce_i) begin
         state     <= next_state;
         sclk_q    <= spi_sclk_i;
         sclk_prev <= sclk_q;
         if (next_state != state) begin
            bit_cnt <= 5'h00;
         end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         addr    <= 8'h00;
         data_sh <= 23'h00_0000;
      end else if (ce_i && sclk_rise) begin
         if (state == SPI_ADDR) begin
            addr <= rd_addr;
         end
         if (state == SPI_DATA) begin
            data_sh <= wr_data[22:0];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         rd_sh      <= 24'h00_0000;
         spi_miso_o <= 1'b0;
      end else if (ce_i) begin
         if (addr_done) begin
            rd_sh <= read_en ? {8'h00, rd_value} : 24'h00_0000;
         end else if (sclk_fall && state == SPI_DATA) begin
            spi_miso_o <= rd_sh[23];
            rd_sh      <= {rd_sh[22:0], 1'b0};
         end
         if (spi_cs_n_i) begin
            spi_miso_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         read_en <= CTRL_RESET;
      end else if (ce_i && wr_fire && addr == REG_CONTROL) begin
         read_en <= wr_data[CTRL_READ_BIT];
      end
   end

   // ==========================================================
   // Edge and period registers
   genvar g;
   generate
      for (g = 1; g <= REG_LAST; g++) begin : g_reg
         always_ff @(posedge mclk_i or negedge rst_sync) begin
            if (!rst_sync) begin
               regs[g] <= EDGE_RESET;
            end else if (ce_i && wr_fire && wr_allowed && addr == 8'(g)) begin
               regs[g] <= wr_data[15:0];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Time base
   logic             wrap;
   logic [CNT_W-1:0] next_cnt;
   logic [15:0]      period;

   assign period   = regs[REG_PERIOD_TERMINAL_COUNT[4:0]];
   assign wrap     = (cnt == period);
   assign next_cnt = wrap ? 16'h0000 : cnt + 16'h0001;

   always_ff @(posedge mclk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         cnt <= 16'h0000;
      end else if (ce_i && tick) begin
         cnt <= next_cnt;
      end
   end

   // ==========================================================
   // Compare units
   logic [PAIR_COUNT-1:0] pair_q;
   logic [PAIR_COUNT-1:0] next_pair;
   logic                  adc_q;

   generate
      for (g = 0; g < PAIR_COUNT; g++) begin : g_cmp
         assign next_pair[g] = (next_cnt == regs[2*g+1]) | (pair_q[g] & (cnt != regs[2*g+2]));
         always_ff @(posedge mclk_i or negedge rst_sync) begin
            if (!rst_sync) begin
               pair_q[g] <= 1'b0;
            end else if (ce_i && tick) begin
               pair_q[g] <= next_pair[g];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_i or negedge rst_sync) begin
      if (!rst_sync) begin
         adc_q <= 1'b0;
      end else if (ce_i && tick) begin
         adc_q <= |next_pair[PAIR_COUNT-1:ADC_FIRST];
      end
   end

   // ==========================================================
   // Outputs
   assign red_sample_o          = pair_q[0];
   assign red_light_o           = pair_q[1];
   assign red_ambient_sample_o  = pair_q[2];
   assign ir_sample_o           = pair_q[3];
   assign ir_light_o            = pair_q[4];
   assign ir_ambient_sample_o   = pair_q[5];
   assign red_convert_o         = pair_q[6];
   assign red_ambient_convert_o = pair_q[7];
   assign ir_convert_o          = pair_q[8];
   assign ir_ambient_convert_o  = pair_q[9];
   assign adc_clear_o           = adc_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_sync);

   sequence s_step;
      ce_i && tick;
   endsequence

   sequence s_period_end;
      s_step ##0 (cnt == period);
   endsequence

   sequence s_frame_write;
      ce_i && wr_fire && wr_allowed && addr == REG_PERIOD_TERMINAL_COUNT;
   endsequence

   AST_COUNT_WRAP: assert property (s_period_end |=> cnt == 16'h0000)
      else $error("Counter did not return to zero at period end");

   AST_COUNT_STEP: assert property ((s_step ##0 cnt != period) |=> cnt == $past(cnt) + 16'h0001)
      else $error("Counter did not advance by one");

   AST_COUNT_HOLD: assert property (!(ce_i && tick) |=> $stable(cnt))
      else $error("Counter moved without a timer tick");

   AST_CLK_TOGGLE: assert property ((ce_i && osc_rise) |=> clk_out_o != $past(clk_out_o))
      else $error("Clock output missed an oscillator edge");

   AST_TICK_HALF: assert property ((ce_i && osc_rise && !clk_out_o) |=> $stable(cnt))
      else $error("Timer ticked on every oscillator edge");

   AST_START_SETS: assert property ((s_step ##0 next_cnt == regs[1]) |=> red_sample_o)
      else $error("Output missed its start value");

   AST_STOP_CLEARS: assert property ((s_step ##0 cnt == regs[2] && next_cnt != regs[1]) |=> !red_sample_o)
      else $error("Output did not drop after its stop value");

   sequence s_single_start;
      s_step ##0 (next_cnt == regs[1] && regs[1] == regs[2] && next_cnt != period);
   endsequence

   AST_ONE_CYCLE: assert property (s_single_start |=> red_sample_o ##0 (cnt == regs[2]))
      else $error("Equal start and stop did not give a single pulse");

   AST_ADC_PULSE: assert property ((s_step ##0 next_cnt == regs[25]) |=> adc_clear_o)
      else $error("Third ADC clear pulse missing");

   AST_OUT_HOLD: assert property (!(ce_i && tick) |=> $stable(pair_q) && $stable(adc_q))
      else $error("Compare output changed without a tick");

   AST_PERIOD_WRITE: assert property (s_frame_write |=> period == $past(wr_data[15:0]))
      else $error("Period write did not land");

   sequence s_single_stop;
      s_step ##0 (red_sample_o && regs[1] == regs[2] && cnt == regs[2] && next_cnt != regs[1]);
   endsequence

   sequence s_locked_write;
      ce_i && wr_fire && read_en && addr == REG_PERIOD_TERMINAL_COUNT;
   endsequence

   sequence s_last_edge_write;
      ce_i && wr_fire && wr_allowed && addr == REG_ADC_CLEAR3_END;
   endsequence

   sequence s_frame_over;
      ce_i && state == SPI_DONE && !spi_cs_n_i;
   endsequence

   AST_ONE_CYCLE_END: assert property (s_single_stop |=> !red_sample_o)
      else $error("Equal start and stop held longer than one cycle");

   AST_ADC_FIRST: assert property ((s_step ##0 next_cnt == regs[21]) |=> adc_clear_o)
      else $error("First ADC clear pulse missing");

   AST_ADC_SECOND: assert property ((s_step ##0 next_cnt == regs[23]) |=> adc_clear_o)
      else $error("Second ADC clear pulse missing");

   AST_ADC_LAST: assert property ((s_step ##0 next_cnt == regs[27]) |=> adc_clear_o)
      else $error("Fourth ADC clear pulse missing");

   AST_CONVERT_SET: assert property ((s_step ##0 next_cnt == regs[19]) |=> ir_ambient_convert_o)
      else $error("Convert output missed its start value");

   AST_LIGHT_SET: assert property ((s_step ##0 next_cnt == regs[3]) |=> red_light_o)
      else $error("Light output missed its start value");

   AST_LIGHT_CLEAR: assert property ((s_step ##0 cnt == regs[4] && next_cnt != regs[3]) |=> !red_light_o)
      else $error("Light output did not drop after its stop value");

   AST_MISO_IDLE: assert property ((ce_i && spi_cs_n_i) |=> !spi_miso_o)
      else $error("Serial output not low while deselected");

   AST_LOCKED_WRITE: assert property (s_locked_write |=> $stable(period))
      else $error("Period changed while writes were locked");

   AST_EDGE_WRITE: assert property (s_last_edge_write |=> regs[28] == $past(wr_data[15:0]))
      else $error("Edge register write did not land");

   AST_DONE_HOLD: assert property (s_frame_over |=> state == SPI_DONE)
      else $error("Serial port left the finished frame early");

endmodule

// File: inc/pulse_timer_pkg.sv
package pulse_timer_pkg;

   // ==========================================================
   // Widths and counts
   localparam int CNT_W       = 16;
   localparam int ADDR_W      = 8;
   localparam int DATA_W      = 24;
   localparam int BITCNT_W    = 5;
   localparam int PAIR_COUNT  = 14;
   localparam int ADC_FIRST   = 10;
   localparam int REG_LAST    = 29;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] REG_CONTROL                   = 8'h00;
   localparam logic [7:0] REG_RED_SAMPLE_START          = 8'h01;
   localparam logic [7:0] REG_RED_SAMPLE_END            = 8'h02;
   localparam logic [7:0] REG_RED_LIGHT_START           = 8'h03;
   localparam logic [7:0] REG_RED_LIGHT_END             = 8'h04;
   localparam logic [7:0] REG_RED_AMBIENT_SAMPLE_START  = 8'h05;
   localparam logic [7:0] REG_RED_AMBIENT_SAMPLE_END    = 8'h06;
   localparam logic [7:0] REG_IR_SAMPLE_START           = 8'h07;
   localparam logic [7:0] REG_IR_SAMPLE_END             = 8'h08;
   localparam logic [7:0] REG_IR_LIGHT_START            = 8'h09;
   localparam logic [7:0] REG_IR_LIGHT_END              = 8'h0A;
   localparam logic [7:0] REG_IR_AMBIENT_SAMPLE_START   = 8'h0B;
   localparam logic [7:0] REG_IR_AMBIENT_SAMPLE_END     = 8'h0C;
   localparam logic [7:0] REG_RED_CONVERT_START         = 8'h0D;
   localparam logic [7:0] REG_RED_CONVERT_END           = 8'h0E;
   localparam logic [7:0] REG_RED_AMBIENT_CONVERT_START = 8'h0F;
   localparam logic [7:0] REG_RED_AMBIENT_CONVERT_END   = 8'h10;
   localparam logic [7:0] REG_IR_CONVERT_START          = 8'h11;
   localparam logic [7:0] REG_IR_CONVERT_END            = 8'h12;
   localparam logic [7:0] REG_IR_AMBIENT_CONVERT_START  = 8'h13;
   localparam logic [7:0] REG_IR_AMBIENT_CONVERT_END    = 8'h14;
   localparam logic [7:0] REG_ADC_CLEAR0_START          = 8'h15;
   localparam logic [7:0] REG_ADC_CLEAR0_END            = 8'h16;
   localparam logic [7:0] REG_ADC_CLEAR1_START          = 8'h17;
   localparam logic [7:0] REG_ADC_CLEAR1_END            = 8'h18;
   localparam logic [7:0] REG_ADC_CLEAR2_START          = 8'h19;
   localparam logic [7:0] REG_ADC_CLEAR2_END            = 8'h1A;
   localparam logic [7:0] REG_ADC_CLEAR3_START          = 8'h1B;
   localparam logic [7:0] REG_ADC_CLEAR3_END            = 8'h1C;
   localparam logic [7:0] REG_PERIOD_TERMINAL_COUNT     = 8'h1D;
   localparam logic [7:0] REG_TIMER_VALUE               = 8'h1E;

   // ==========================================================
   // Fields and reset values
   localparam int          CTRL_READ_BIT = 0;
   localparam logic [15:0] EDGE_RESET    = 16'h0000;
   localparam logic        CTRL_RESET    = 1'b0;

   // ==========================================================
   // Timing
   localparam int OSC_DIVIDE    = 2;
   localparam int EDGE_STEP_PS  = 250000;
   localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
   localparam logic [4:0] DATA_LAST_BIT = 5'h17;

   // ==========================================================
   // Serial port phases
   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_ADDR = 2'b01,
      SPI_DATA = 2'b11,
      SPI_DONE = 2'b10
   } spi_state_t;

endpackage

// File: tb/spi_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host controller model on the serial register port
module spi_host (
   input  wire logic mclk_i,
   input  wire logic host_clk_i,
   input  wire logic miso_i,
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      mosi_o
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
   end

   // Mode 0 frame, address then data, both MSB first
   task automatic xfer(input logic [7:0] addr, input logic [23:0] wdata, output logic [23:0] rdata);
      logic [31:0] frame;
      frame = {addr, wdata};
      rdata = 24'h00_0000;
      @(posedge mclk_i);
      cs_n_o <= 1'b0;
      for (int i = 31; i >= 0; i--) begin
         mosi_o <= frame[i];
         repeat (6) @(posedge mclk_i);
         // Last rise just after a timer tick keeps writes clear of the next tick
         if (i == 0) begin
            @(negedge host_clk_i);
            @(posedge mclk_i);
         end
         if (i < 24) begin
            rdata[i] = miso_i;
         end
         sclk_o <= 1'b1;
         repeat (4) @(posedge mclk_i);
         sclk_o <= 1'b0;
      end
      repeat (6) @(posedge mclk_i);
      cs_n_o <= 1'b1;
      mosi_o <= ~mosi_o;
   endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
// ==========================================================
// Timer bench: serial setup, output model, register readback
module testbench
   import pulse_timer_pkg::*;
;
   // Corner set, then an ordered sequence; index is the address
   localparam logic [15:0] CFG [0:1][1:29] = '{
      '{3, 3, 0, 12, 12, 0, 2, 10, 5, 4, 7, 7, 0, 0, 12, 12, 1, 2, 11, 11, 4, 6, 5, 8, 10, 10, 12, 1, 12},
      '{60, 78, 58, 79, 2, 18, 22, 38, 20, 39, 42, 56, 2, 19, 22, 39, 42, 59, 62, 79,
        0, 1, 20, 21, 40, 41, 60, 61, 79}};

   logic        mclk    = 1'b0;
   logic        rst_n   = 1'b0;
   logic        ce      = 1'b1;
   logic        osc_clk = 1'b0;
   logic [4:0]  oc      = 5'h00;
   logic        cs_n, sclk, mosi, miso, clk_out, clk_d, rd_en, seen_rise;
   logic [10:0] outs;
   logic [15:0] regs [0:31];
   logic [15:0] mcnt;
   logic [13:0] mq;
   int          per_cnt, n_errors, tests_run;

   pulse_sequence_timer u_pulse_sequence_timer (
      .mclk_i                (mclk),
      .rst_n_i               (rst_n),
      .ce_i                  (ce),
      .osc_clk_i             (osc_clk),
      .spi_cs_n_i            (cs_n),
      .spi_sclk_i            (sclk),
      .spi_mosi_i            (mosi),
      .spi_miso_o            (miso),
      .clk_out_o             (clk_out),
      .red_sample_o          (outs[0]),
      .red_light_o           (outs[1]),
      .red_ambient_sample_o  (outs[2]),
      .ir_sample_o           (outs[3]),
      .ir_light_o            (outs[4]),
      .ir_ambient_sample_o   (outs[5]),
      .red_convert_o         (outs[6]),
      .red_ambient_convert_o (outs[7]),
      .ir_convert_o          (outs[8]),
      .ir_ambient_convert_o  (outs[9]),
      .adc_clear_o           (outs[10])
   );

   spi_host u_spi_host (
      .mclk_i     (mclk),
      .host_clk_i (clk_out),
      .miso_i     (miso),
      .cs_n_o     (cs_n),
      .sclk_o     (sclk),
      .mosi_o     (mosi)
   );

   always #5 mclk = ~mclk;

   // Oscillator near 8 MHz: two periods span 25 system cycles
   always @(posedge mclk) begin
      oc      <= (oc == 5'h18) ? 5'h00 : oc + 5'h01;
      osc_clk <= (oc < 5'h06) || (oc >= 5'h0c && oc < 5'h12);
   end

   task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [13:0] next_q(input logic [15:0] cnt, input logic [13:0] q);
      logic [15:0] nc;
      nc = (cnt == regs[29]) ? 16'h0000 : cnt + 16'h0001;
      for (int k = 0; k < 14; k++)
         next_q[k] = (nc == regs[2*k+1]) | (q[k] & (cnt != regs[2*k+2]));
   endfunction

   // Model steps on each tick, compares halfway to the next one
   always @(posedge mclk) begin
      clk_d   <= clk_out;
      per_cnt <= per_cnt + 1;
      if (!rst_n) begin
         mcnt <= 16'h0000;
         mq   <= 14'h0000;
      end else if (clk_d && !clk_out) begin
         mq   <= next_q(mcnt, mq);
         mcnt <= (mcnt == regs[29]) ? 16'h0000 : mcnt + 16'h0001;
      end else if (!clk_d && clk_out) begin
         per_cnt   <= 1;
         seen_rise <= 1'b1;
         if (seen_rise) begin
            check("clk_out period", 24'(per_cnt), 24'(OSC_DIVIDE * 25 / 2));
         end
         check("timing outputs", 24'(outs), 24'({|mq[13:10], mq[9:0]}));
      end
   end

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      logic [23:0] rd;
      u_spi_host.xfer(a, {8'($urandom), v}, rd);
      if (a >= REG_RED_SAMPLE_START && a <= REG_PERIOD_TERMINAL_COUNT && !rd_en) begin
         regs[a] = v;
      end
      if (a == REG_CONTROL) begin
         rd_en = v[CTRL_READ_BIT];
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      logic [23:0] rd;
      u_spi_host.xfer(a, 24'h00_0000, rd);
      check("read data", rd, {8'h00, exp});
   endtask

   task automatic readback();
      wr(REG_CONTROL, 16'h0001);
      for (int a = 1; a < 30; a++) begin
         rd_chk(8'(a), regs[a]);
      end
      wr(REG_RED_AMBIENT_SAMPLE_START, ~regs[5]);
      rd_chk(REG_RED_AMBIENT_SAMPLE_START, regs[5]);
      rd_chk(8'h1F, 16'h0000);
      rd_chk(REG_CONTROL, 16'h0001);
      wr(REG_CONTROL, 16'h0000);
      rd_chk(REG_TIMER_VALUE, 16'h0000);
   endtask

   task automatic close_out();
      $display("Checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge mclk);
      n_errors++;
      close_out();
   end

   initial begin
      logic [15:0] v;
      logic [15:0] per;
      int          seed;
      n_errors  = 0;
      tests_run = 0;
      per_cnt   = 0;
      clk_d     = 1'b0;
      rd_en     = CTRL_RESET;
      seen_rise = 1'b0;
      seed      = $urandom(32'hd1b2);
      for (int a = 0; a < 32; a++) begin
         regs[a] = EDGE_RESET;
      end
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      readback();
      // Periods never fall from one set to the next so the counter never overruns
      for (int c = 0; c < 3; c++) begin
         per = (c == 1) ? 16'(12 + $urandom % 20) : CFG[c/2][29];
         for (int a = 1; a < 30; a++) begin
            v = (c == 1) ? 16'($urandom % (32'(per) + 1)) : CFG[c/2][a];
            if (a == 29) begin
               v = per;
            end
            wr(8'(a), v);
         end
         if (c == 0) begin
            readback();
         end
         repeat (75 * (32'(per) + 1)) @(posedge mclk);
      end
      close_out();
   end
endmodule
